// file: logic/ppd_pkg.sv
// constants for the port pin and direction control block
// assumes an axi4-lite master and word-aligned register slots
// Function
// RULE_01: serial open-drain bit makes driven serial pins open-drain outputs.
// RULE_02: serial control bit 5 always reads back as zero.
// RULE_03: low-address port: inputs in single-chip, address outputs when expanded; code lets the direction bits make single-chip pins outputs.
// RULE_04: select port resets to inputs; expanded mode assigns bit 7 to program select.
// RULE_05: expanded mode forces enabled chip-select pins of select port to output.
// RULE_06: enabled pulse-width channels force their select-port pins to output.
// RULE_07: override leaves direction bit alone; direction bit rules when released.
// RULE_08: direction bit 0 means input, 1 means output; all reset to 0.
// RULE_09: expanded mode forces expansion port bit 7 out as read/write strobe.
// RULE_10: expansion port resets to inputs; bit 7 is strobe when expanded.
// RULE_11: assignment bit 0 gives general I/O, 1 gives expansion address line.
// RULE_12: enabled expansion line forces output; direction bit resumes when cleared.
// RULE_13: pull-up assignment bits 7 to 4 always read as zero.
// RULE_14: per-port pull-up bit acts only while global pull-up enable is set.
// RULE_15: expanded mode ignores pull-up bits of both address ports.
// RULE_16: forced pins are driven from their function signal, not the latch.
package ppd_pkg;
  // register index; byte address is four times the index
  localparam logic [7:0] IDX_LOW_DIR    = 8'h03;
  localparam logic [7:0] IDX_LOW_DATA   = 8'h05;
  localparam logic [7:0] IDX_PULLUP     = 8'h2c;
  localparam logic [7:0] IDX_EXP_ASSIGN = 8'h2d;
  localparam logic [7:0] IDX_SEL_DIR    = 8'h7d;
  localparam logic [7:0] IDX_EXP_DATA   = 8'h7e;
  localparam logic [7:0] IDX_EXP_DIR    = 8'h7f;
  localparam logic [7:0] IDX_SERIAL_CTL = 8'h40;
  localparam logic [7:0] IDX_ANALOG     = 8'h41;
  localparam logic [7:0] IDX_SEL_DATA   = 8'h42;
  localparam logic [7:0] IDX_CONFIG     = 8'h43;
  // implemented-bit masks
  localparam logic [7:0] SERIAL_MASK    = 8'hdf;
  localparam logic [7:0] PULLUP_MASK    = 8'h0f;
  localparam logic [7:0] ASSIGN_MASK    = 8'h3f;
  localparam logic [7:0] CONFIG_MASK    = 8'h03;
  // field positions
  localparam int BIT_OPEN_DRAIN = 6;
  localparam int BIT_GLOBAL_PU  = 0;
  localparam int BIT_PROG_SEL   = 1;
  localparam int PU_SEL         = 0;
  localparam int PU_EXP         = 1;
  localparam int PU_LOW         = 2;
  localparam int PU_HIGH        = 3;
  // reset values
  localparam logic [7:0] RST_DIR    = 8'h00;
  localparam logic [7:0] RST_DATA   = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_ASSIGN = 8'h00;
  localparam logic [7:0] RST_SERIAL = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {
    PPD_INIT_W0   = 2'b00,
    PPD_INIT_W1   = 2'b01,
    PPD_INIT_LOAD = 2'b10,
    PPD_INIT_RUN  = 2'b11
  } ppd_init_t;
endpackage

// file: logic/ppd_port_ctrl.sv
// port data, direction, assignment and pull-up control with axi4-lite
// assumes chip-select, pulse-width, serial and bus units on mclk_in
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module ppd_port_ctrl
  import ppd_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic [9:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [9:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        mode_expanded_in,
  input  wire logic        mode_boot_in,
  input  wire logic [7:0]  analog_pin_in,
  input  wire logic [7:0]  low_addr_pin_in,
  output logic [7:0]       low_addr_pin_out,
  output logic [7:0]       low_addr_pin_oe_out,
  input  wire logic [7:0]  low_addr_bus_in,
  input  wire logic [7:0]  exp_pin_in,
  output logic [7:0]       exp_pin_out,
  output logic [7:0]       exp_pin_oe_out,
  input  wire logic        rw_strobe_in,
  input  wire logic [5:0]  expansion_address_lines_in,
  input  wire logic [7:0]  sel_pin_in,
  output logic [7:0]       sel_pin_out,
  output logic [7:0]       sel_pin_oe_out,
  input  wire logic [3:0]  chip_select_enable_in,
  input  wire logic [3:0]  chip_select_in,
  input  wire logic [3:0]  pwm_enable_in,
  input  wire logic [3:0]  pwm_in,
  input  wire logic [1:0]  serial_drive_in,
  input  wire logic [1:0]  serial_data_in,
  input  wire logic [1:0]  serial_pin_in,
  output logic [1:0]       serial_pin_out,
  output logic [1:0]       serial_pin_oe_out,
  output logic [1:0]       serial_rx_out,
  output logic [7:0]       low_addr_pullup_out,
  output logic [7:0]       exp_pullup_out,
  output logic [7:0]       sel_pullup_out,
  output logic             high_addr_pullup_out
);
  import ppd_pkg::*;

  // ************************************************************
  // pin synchroniser
  // ************************************************************
  localparam int SYNC_W = 36;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] pins_raw;
  assign pins_raw = {mode_expanded_in, mode_boot_in, serial_pin_in,
                     sel_pin_in, exp_pin_in, low_addr_pin_in,
                     analog_pin_in};
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
    end
  end
  logic [7:0] analog_s;
  logic [7:0] low_s;
  logic [7:0] exp_s;
  logic [7:0] sel_s;
  logic [1:0] ser_s;
  logic       boot_s;
  logic       expd_s;
  assign {expd_s, boot_s, ser_s, sel_s, exp_s, low_s, analog_s} = sync_q;
  assign serial_rx_out = ser_s;

  function automatic logic idx_mapped(input logic [7:0] idx,
                                      input logic       exp);
    case (idx)
      IDX_LOW_DATA: idx_mapped = !exp;
      IDX_LOW_DIR, IDX_PULLUP, IDX_EXP_ASSIGN, IDX_SEL_DIR,
      IDX_EXP_DATA, IDX_EXP_DIR, IDX_SERIAL_CTL, IDX_ANALOG,
      IDX_SEL_DATA, IDX_CONFIG: idx_mapped = 1'b1;
      default: idx_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] port_rd(input logic [7:0] latch,
                                         input logic [7:0] pin,
                                         input logic [7:0] oe);
    port_rd = (latch & oe) | (pin & ~oe);
  endfunction

  // ************************************************************
  // registers, mode capture and bus slave
  // ************************************************************
  ppd_init_t   st_q,  st_d;
  logic        exp_q, exp_d;
  logic [7:0]  fdir_q, fdir_d, fdat_q, fdat_d;
  logic [7:0]  gdir_q, gdir_d, gdat_q, gdat_d;
  logic [7:0]  hdir_q, hdir_d, hdat_q, hdat_d;
  logic [7:0]  pull_q, pull_d, asgn_q, asgn_d;
  logic [7:0]  sctl_q, sctl_d, cfg_q, cfg_d;
  logic        awh_q, awh_d, wh_q, wh_d;
  logic [7:0]  awi_q, awi_d, wd_q, wd_d;
  logic        ws_q, ws_d;
  logic        bv_q, bv_d, rv_q, rv_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [7:0]  rd_q, rd_d;
  logic [7:0]  ari;
  logic [7:0]  rbyte;
  logic [7:0]  pf_oe_q, pg_oe_q, ph_oe_q;

  assign ari = s_axi_araddr_in[9:2];
  assign s_axi_awready_out = !awh_q && !bv_q;
  assign s_axi_wready_out  = !wh_q && !bv_q;
  assign s_axi_arready_out = !rv_q;
  assign s_axi_bvalid_out  = bv_q;
  assign s_axi_bresp_out   = br_q;
  assign s_axi_rvalid_out  = rv_q;
  assign s_axi_rresp_out   = rr_q;
  assign s_axi_rdata_out   = {24'h000000, rd_q};

  always_comb begin
    case (ari)
      IDX_LOW_DIR:    rbyte = fdir_q;
      IDX_LOW_DATA:   rbyte = port_rd(fdat_q, low_s, pf_oe_q);
      IDX_PULLUP:     rbyte = pull_q & PULLUP_MASK;   // [RULE_13]
      IDX_EXP_ASSIGN: rbyte = asgn_q & ASSIGN_MASK;
      IDX_SEL_DIR:    rbyte = hdir_q;
      IDX_EXP_DATA:   rbyte = port_rd(gdat_q, exp_s, pg_oe_q);
      IDX_EXP_DIR:    rbyte = gdir_q;
      IDX_SERIAL_CTL: rbyte = sctl_q & SERIAL_MASK;   // [RULE_02]
      IDX_ANALOG:     rbyte = analog_s;
      IDX_SEL_DATA:   rbyte = port_rd(hdat_q, sel_s, ph_oe_q);
      IDX_CONFIG:     rbyte = cfg_q & CONFIG_MASK;
      default:        rbyte = 8'h00;
    endcase
  end

  always_comb begin
    st_d = st_q;
    exp_d = exp_q;
    fdir_d = fdir_q;
    fdat_d = fdat_q;
    gdir_d = gdir_q;
    gdat_d = gdat_q;
    hdir_d = hdir_q;
    hdat_d = hdat_q;
    pull_d = pull_q;
    asgn_d = asgn_q;
    sctl_d = sctl_q;
    cfg_d = cfg_q;
    awh_d = awh_q;
    awi_d = awi_q;
    wh_d = wh_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rr_d = rr_q;
    rd_d = rd_q;
    // straps settle through the synchroniser before capture
    case (st_q)
      PPD_INIT_W0: st_d = PPD_INIT_W1;
      PPD_INIT_W1: st_d = PPD_INIT_LOAD;
      PPD_INIT_LOAD: begin
        st_d = PPD_INIT_RUN;
        exp_d = expd_s;
        sctl_d[BIT_OPEN_DRAIN] = boot_s;
        cfg_d[BIT_PROG_SEL] = expd_s;                 // [RULE_04]
      end
      PPD_INIT_RUN: st_d = PPD_INIT_RUN;
      default: st_d = PPD_INIT_W0;
    endcase
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      awh_d = 1'b1;
      awi_d = s_axi_awaddr_in[9:2];
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      wh_d = 1'b1;
      wd_d = s_axi_wdata_in[7:0];
      ws_d = s_axi_wstrb_in[0];
    end
    if (awh_q && wh_q) begin
      awh_d = 1'b0;
      wh_d = 1'b0;
      bv_d = 1'b1;
      br_d = idx_mapped(awi_q, exp_q) ? RESP_OKAY : RESP_DECERR;
      // low-address data drops out of the map when expanded
      if (ws_q && idx_mapped(awi_q, exp_q)) begin   // [RULE_03]
        case (awi_q)
          IDX_LOW_DIR:    fdir_d = wd_q;
          IDX_LOW_DATA:   fdat_d = wd_q;
          IDX_PULLUP:     pull_d = wd_q & PULLUP_MASK;
          IDX_EXP_ASSIGN: asgn_d = wd_q & ASSIGN_MASK;
          IDX_SEL_DIR:    hdir_d = wd_q;
          IDX_EXP_DATA:   gdat_d = wd_q;
          IDX_EXP_DIR:    gdir_d = wd_q;
          IDX_SERIAL_CTL: sctl_d = wd_q & SERIAL_MASK;
          IDX_SEL_DATA:   hdat_d = wd_q;
          IDX_CONFIG:     cfg_d = wd_q & CONFIG_MASK;
          default:        cfg_d = cfg_q;
        endcase
      end
    end
    if (bv_q && s_axi_bready_in) begin
      bv_d = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      rv_d = 1'b1;
      rd_d = idx_mapped(ari, exp_q) ? rbyte : 8'h00;
      rr_d = idx_mapped(ari, exp_q) ? RESP_OKAY : RESP_DECERR;
    end else if (rv_q && s_axi_rready_in) begin
      rv_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= PPD_INIT_W0;
      exp_q <= 1'b0;
      fdir_q <= RST_DIR;                              // [RULE_08]
      gdir_q <= RST_DIR;
      hdir_q <= RST_DIR;
      fdat_q <= RST_DATA;
      gdat_q <= RST_DATA;
      hdat_q <= RST_DATA;
      pull_q <= RST_PULLUP;
      asgn_q <= RST_ASSIGN;
      sctl_q <= RST_SERIAL;
      cfg_q <= RST_CONFIG;
      awh_q <= 1'b0;
      awi_q <= 8'h00;
      wh_q <= 1'b0;
      wd_q <= 8'h00;
      ws_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= RESP_OKAY;
      rv_q <= 1'b0;
      rr_q <= RESP_OKAY;
      rd_q <= 8'h00;
    end else begin
      st_q <= st_d;
      exp_q <= exp_d;
      fdir_q <= fdir_d;
      gdir_q <= gdir_d;
      hdir_q <= hdir_d;
      fdat_q <= fdat_d;
      gdat_q <= gdat_d;
      hdat_q <= hdat_d;
      pull_q <= pull_d;
      asgn_q <= asgn_d;
      sctl_q <= sctl_d;
      cfg_q <= cfg_d;
      awh_q <= awh_d;
      awi_q <= awi_d;
      wh_q <= wh_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
    end
  end

  // ************************************************************
  // pin direction and drive
  // ************************************************************
  logic [7:0] g_force, g_alt, h_force, h_alt;
  logic [3:0] cs_eff;
  logic       od, pu_on;
  logic [7:0] pf_oe_d, pf_out_d, pg_oe_d, pg_out_d, ph_oe_d, ph_out_d;
  logic [1:0] sr_oe_d, sr_out_d, sr_oe_q, sr_out_q;
  logic [7:0] pf_out_q, pg_out_q, ph_out_q;
  logic [7:0] puf_d, pug_d, puh_d, puf_q, pug_q, puh_q;
  logic       pub_d, pub_q;

  assign od = sctl_q[BIT_OPEN_DRAIN];
  assign pu_on = cfg_q[BIT_GLOBAL_PU];
  assign cs_eff = chip_select_enable_in | {cfg_q[BIT_PROG_SEL], 3'h0};
  // pin 6 of the expansion port has no alternate function
  assign g_force = {exp_q, 1'b0, asgn_q[5:0]};        // [RULE_09] [RULE_12]
  assign g_alt = {rw_strobe_in, 1'b0, expansion_address_lines_in};
  assign h_force = {cs_eff & {4{exp_q}}, pwm_enable_in};  // [RULE_05] [RULE_06]
  assign h_alt = {chip_select_in, pwm_in};

  always_comb begin
    pf_oe_d = exp_q ? 8'hff : fdir_q;                 // [RULE_03] [RULE_08]
    pf_out_d = exp_q ? low_addr_bus_in : fdat_q;
    // direction bits are only masked, never rewritten
    pg_oe_d = g_force | gdir_q;                       // [RULE_07] [RULE_11]
    pg_out_d = (g_force & g_alt) | (~g_force & gdat_q);   // [RULE_16]
    ph_oe_d = h_force | hdir_q;                       // [RULE_07]
    ph_out_d = (h_force & h_alt) | (~h_force & hdat_q);   // [RULE_16]
    // pull-ups only on undriven low, expansion and select pins and on the high-address port, and only with the global enable
    puf_d = {8{pu_on & pull_q[PU_LOW] & ~exp_q}} & ~pf_oe_d; // [RULE_14] [RULE_15]
    pug_d = {8{pu_on & pull_q[PU_EXP]}} & ~pg_oe_d;   // [RULE_10]
    puh_d = {8{pu_on & pull_q[PU_SEL]}} & ~ph_oe_d;   // [RULE_04]
    pub_d = pu_on & pull_q[PU_HIGH] & ~exp_q;         // [RULE_15]
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_serial
      // open-drain: only a low is driven, a high releases the pin
      always_comb begin
        sr_oe_d[gi] = serial_drive_in[gi] & (~od | ~serial_data_in[gi]); // [RULE_01]
        sr_out_d[gi] = serial_data_in[gi] & ~od;      // [RULE_01]
      end
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pf_oe_q <= 8'h00;
      pf_out_q <= 8'h00;
      pg_oe_q <= 8'h00;
      pg_out_q <= 8'h00;
      ph_oe_q <= 8'h00;
      ph_out_q <= 8'h00;
      sr_oe_q <= 2'h0;
      sr_out_q <= 2'h0;
      puf_q <= 8'h00;
      pug_q <= 8'h00;
      puh_q <= 8'h00;
      pub_q <= 1'b0;
    end else begin
      pf_oe_q <= pf_oe_d;
      pf_out_q <= pf_out_d;
      pg_oe_q <= pg_oe_d;
      pg_out_q <= pg_out_d;
      ph_oe_q <= ph_oe_d;
      ph_out_q <= ph_out_d;
      sr_oe_q <= sr_oe_d;
      sr_out_q <= sr_out_d;
      puf_q <= puf_d;
      pug_q <= pug_d;
      puh_q <= puh_d;
      pub_q <= pub_d;
    end
  end

  assign low_addr_pin_oe_out = pf_oe_q;
  assign low_addr_pin_out = pf_out_q;
  assign exp_pin_oe_out = pg_oe_q;
  assign exp_pin_out = pg_out_q;
  assign sel_pin_oe_out = ph_oe_q;
  assign sel_pin_out = ph_out_q;
  assign serial_pin_oe_out = sr_oe_q;
  assign serial_pin_out = sr_out_q;
  assign low_addr_pullup_out = puf_q;
  assign exp_pullup_out = pug_q;
  assign sel_pullup_out = puh_q;
  assign high_addr_pullup_out = pub_q;

  // ************************************************************
  // assertions
  // ************************************************************
  logic live;
  assign live = (st_q != PPD_INIT_W0);

  property p_open_drain;
    @(posedge mclk_in) disable iff (!resetn_in)
    live && od |=> sr_out_q == 2'h0 &&
      (sr_oe_q & ~$past(serial_drive_in)) == 2'h0;
  endproperty
  a_open_drain: assert property (p_open_drain) // [RULE_01]
    else $error("serial pin driven high in open-drain mode");

  property p_serial_b5;
    @(posedge mclk_in) disable iff (!resetn_in)
    s_axi_arvalid_in && s_axi_arready_out && ari == IDX_SERIAL_CTL
      |=> s_axi_rdata_out[5] == 1'b0;
  endproperty
  a_serial_b5: assert property (p_serial_b5) // [RULE_02]
    else $error("serial control bit 5 read as one");

  property p_low_exp;
    @(posedge mclk_in) disable iff (!resetn_in)
    live && exp_q |=> pf_oe_q == 8'hff &&
      pf_out_q == $past(low_addr_bus_in);
  endproperty
  a_low_exp: assert property (p_low_exp) // [RULE_03]
    else $error("low-address port not driving address when expanded");

  property p_prog_sel;
    @(posedge mclk_in) disable iff (!resetn_in)
    st_q == PPD_INIT_LOAD && expd_s |=> cfg_q[BIT_PROG_SEL] ##1
      (sel_pin_oe_out[7] && sel_pin_out[7] == $past(chip_select_in[3]));
  endproperty
  a_prog_sel: assert property (p_prog_sel) // [RULE_04]
    else $error("program select not on select port bit 7");

  property p_sel_force;
    @(posedge mclk_in) disable iff (!resetn_in)
    live |=> (($past(h_force) | $past(hdir_q)) ^ ph_oe_q) == 8'h00;
  endproperty
  a_sel_force: assert property (p_sel_force) // [RULE_05] [RULE_06] [RULE_07]
    else $error("select port direction wrong");

  property p_low_dir;
    @(posedge mclk_in) disable iff (!resetn_in)
    live && !exp_q |=> pf_oe_q == $past(fdir_q);
  endproperty
  a_low_dir: assert property (p_low_dir) // [RULE_08]
    else $error("low-address pin direction differs from its bit");

  property p_rw_strobe;
    @(posedge mclk_in) disable iff (!resetn_in)
    live && exp_q |=> exp_pin_oe_out[7] &&
      exp_pin_out[7] == $past(rw_strobe_in);
  endproperty
  a_rw_strobe: assert property (p_rw_strobe) // [RULE_09]
    else $error("strobe not driven on expansion bit 7");

  property p_exp_assign;
    @(posedge mclk_in) disable iff (!resetn_in)
    live |=> pg_oe_q[5:0] == ($past(asgn_q[5:0]) | $past(gdir_q[5:0]))
      && ((pg_out_q[5:0] ^ $past(expansion_address_lines_in))
          & $past(asgn_q[5:0])) == 6'h00;
  endproperty
  a_exp_assign: assert property (p_exp_assign) // [RULE_11] [RULE_12] [RULE_16]
    else $error("expansion address line not forced out");

  property p_pullup_gate;
    @(posedge mclk_in) disable iff (!resetn_in)
    live && (!pu_on || exp_q) |=> puf_q == 8'h00 && !pub_q;
  endproperty
  a_pullup_gate: assert property (p_pullup_gate) // [RULE_14] [RULE_15]
    else $error("address pull-up on while disabled");

  property p_pullup_mask;
    @(posedge mclk_in) disable iff (!resetn_in)
    pull_q[7:4] == 4'h0 && sctl_q[5] == 1'b0;
  endproperty
  a_pullup_mask: assert property (p_pullup_mask) // [RULE_13]
    else $error("unimplemented bit held a one");

  c_write: cover property (@(posedge mclk_in) disable iff (!resetn_in)
    bv_q && br_q == RESP_OKAY);
  c_decerr: cover property (@(posedge mclk_in) disable iff (!resetn_in)
    rv_q && rr_q == RESP_DECERR);
  c_pwm: cover property (@(posedge mclk_in) disable iff (!resetn_in)
    pwm_enable_in[0] && !hdir_q[0] ##1 ph_oe_q[0]);
  c_od: cover property (@(posedge mclk_in) disable iff (!resetn_in)
    od && serial_drive_in[0] ##1 sr_oe_q[0]);
endmodule // ppd_port_ctrl

// file: sim/tb_top.sv
// self-checking bench for the port pin and direction control block
// assumes ppd_pkg and ppd_port_ctrl compiled first; rtl holds assertions
`timescale 1ns/1ps
module tb_top;
  import ppd_pkg::*;
  logic        mclk_in, resetn_in, s_axi_awvalid_in, s_axi_awready_out;
  logic        s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic        s_axi_rvalid_out, s_axi_rready_in, mode_expanded_in;
  logic        mode_boot_in, rw_strobe_in, high_addr_pullup_out;
  logic [9:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in, chip_select_enable_in, chip_select_in;
  logic [3:0]  pwm_enable_in, pwm_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, serial_drive_in;
  logic [1:0]  serial_data_in, serial_pin_in, serial_pin_out;
  logic [1:0]  serial_pin_oe_out, serial_rx_out, resp;
  logic [7:0]  analog_pin_in, low_addr_pin_in, low_addr_pin_out;
  logic [7:0]  low_addr_pin_oe_out, low_addr_bus_in, exp_pin_in;
  logic [7:0]  exp_pin_out, exp_pin_oe_out, sel_pin_in, sel_pin_out;
  logic [7:0]  sel_pin_oe_out, low_addr_pullup_out, exp_pullup_out;
  logic [7:0]  sel_pullup_out, de, dl, v;
  logic [5:0]  expansion_address_lines_in;
  logic [33:0] rd_q[$];
  int          n_fail, tests_run, seed;

  ppd_port_ctrl uut (.*);

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  // ****************************************
  // compare, bus and reset tasks
  // ****************************************
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // readiness sampled mid-cycle: it equals what the next edge sees
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    logic a, w, b;
    int   n;
    a = 1'b0; w = 1'b0; b = 1'b0; n = 0;
    @(posedge mclk_in);
    s_axi_awaddr_in  <= {idx, 2'b00};
    s_axi_wdata_in   <= {24'($random(seed)), val};
    s_axi_wstrb_in   <= 4'h1;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in  <= 1'b1;
    s_axi_bready_in  <= 1'b1;
    while (b !== 1'b1 && n < 100) begin
      @(negedge mclk_in);
      n++;
      a = a | (s_axi_awvalid_in & s_axi_awready_out);
      w = w | (s_axi_wvalid_in & s_axi_wready_out);
      b = s_axi_bvalid_out;
      resp = s_axi_bresp_out;
      @(posedge mclk_in);
      if (a) s_axi_awvalid_in <= 1'b0;
      if (w) s_axi_wvalid_in <= 1'b0;
    end
    // a write that never answers counts against the run
    if (b !== 1'b1) n_fail++;
    s_axi_bready_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                    input logic [1:0] rsp = RESP_OKAY);
    logic t, r;
    int   n;
    r = 1'b0; n = 0;
    rd_q.push_back({rsp, 24'h0, exp});
    @(posedge mclk_in);
    s_axi_araddr_in  <= {idx, 2'b00};
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in  <= 1'b1;
    while (r !== 1'b1 && n < 100) begin
      @(negedge mclk_in);
      n++;
      t = s_axi_arvalid_in & s_axi_arready_out;
      r = s_axi_rvalid_out;
      @(posedge mclk_in);
      if (t) s_axi_arvalid_in <= 1'b0;
    end
    if (r !== 1'b1) n_fail++;
    s_axi_rready_in <= 1'b0;
  endtask

  // oldest noted read result against each read handshake
  always @(negedge mclk_in) begin
    if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in === 1'b1) begin
      if (rd_q.size() > 0)
        cmp_rd({s_axi_rresp_out, s_axi_rdata_out}, rd_q.pop_front());
      else begin
        n_fail++;
        $display("BAD t=%0t got=%h exp=%h", $time, s_axi_rdata_out, 32'h0);
      end
    end
  end

  // pin outputs are registered, so give causes a few edges to land
  task automatic settle;
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask

  // straps are captured once after release, so mode needs a fresh reset
  task automatic do_reset(input logic ex, input logic bt);
    @(posedge mclk_in);
    resetn_in        <= 1'b0;
    mode_expanded_in <= ex;
    mode_boot_in     <= bt;
    {analog_pin_in, low_addr_pin_in, low_addr_bus_in, exp_pin_in}
      <= $random(seed);
    {sel_pin_in, expansion_address_lines_in, rw_strobe_in, chip_select_in,
     pwm_in, serial_data_in, serial_pin_in} <= 27'($random(seed));
    repeat (12) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
  endtask

  task automatic complete_run;
    // a noted read that never came back is a miss too
    if (rd_q.size() != 0) n_fail++;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #300000;
    n_fail++;
    complete_run();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'h8702b134;
    n_fail = 0;
    tests_run = 0;
    resetn_in = 1'b0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
    {s_axi_arvalid_in, s_axi_rready_in, s_axi_wstrb_in} = 6'h0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 52'h0;
    {mode_expanded_in, mode_boot_in, rw_strobe_in, serial_drive_in} = 5'h0;
    {chip_select_enable_in, chip_select_in, pwm_enable_in, pwm_in} = 16'h0;
    {analog_pin_in, low_addr_pin_in, low_addr_bus_in, exp_pin_in} = 32'h0;
    {sel_pin_in, expansion_address_lines_in, serial_data_in} = 16'h0;
    serial_pin_in = 2'h0;
    do_reset(1'b0, 1'b0);
    rd(IDX_LOW_DIR, RST_DIR);
    rd(IDX_EXP_DIR, RST_DIR);
    rd(IDX_SEL_DIR, RST_DIR);
    rd(IDX_SERIAL_CTL, RST_SERIAL);
    rd(IDX_ANALOG, analog_pin_in);
    settle();
    cmp_val({low_addr_pin_oe_out, exp_pin_oe_out}, 16'h0);
    cmp_val(sel_pin_oe_out, 8'h00);
    wr(IDX_SERIAL_CTL, 8'hff);
    rd(IDX_SERIAL_CTL, 8'hdf);
    wr(IDX_PULLUP, 8'hff);
    rd(IDX_PULLUP, 8'h0f);
    wr(IDX_EXP_ASSIGN, 8'hff);
    rd(IDX_EXP_ASSIGN, 8'h3f);
    rd(8'h10, 8'h00, RESP_DECERR);
    wr(8'h10, 8'h00);
    cmp_val(resp, RESP_DECERR);
    de = 8'($random(seed));
    dl = 8'($random(seed));
    v = 8'($random(seed));
    wr(IDX_EXP_DIR, de);
    wr(IDX_EXP_DATA, v);
    settle();
    cmp_val(exp_pin_oe_out, {de[7:6], 6'h3f});
    cmp_val(exp_pin_out[5:0], expansion_address_lines_in);
    cmp_val(exp_pin_out & de & 8'hc0, v & de & 8'hc0);
    rd(IDX_EXP_DIR, de);
    wr(IDX_EXP_ASSIGN, 8'h00);
    settle();
    cmp_val(exp_pin_oe_out, de);
    cmp_val(exp_pin_out & de, v & de);
    rd(IDX_EXP_DATA, (v & de) | (exp_pin_in & ~de));
    wr(IDX_LOW_DIR, dl);
    wr(IDX_LOW_DATA, v);
    pwm_enable_in <= 4'($random(seed));
    chip_select_enable_in <= 4'hf;
    settle();
    cmp_val(low_addr_pin_oe_out, dl);
    cmp_val(low_addr_pin_out & dl, v & dl);
    cmp_val(sel_pin_oe_out, {4'h0, pwm_enable_in});
    cmp_val(sel_pin_out[3:0] & pwm_enable_in, pwm_in & pwm_enable_in);
    wr(IDX_PULLUP, 8'h0f);
    pwm_enable_in <= 4'h0;
    serial_drive_in <= 2'b11;
    serial_data_in <= 2'b01;
    wr(IDX_CONFIG, 8'h00);
    settle();
    cmp_val({low_addr_pullup_out, exp_pullup_out, sel_pullup_out}, 24'h0);
    cmp_val(serial_pin_oe_out, 2'b10);
    cmp_val(serial_pin_out, 2'b00);
    wr(IDX_CONFIG, 8'h01);
    wr(IDX_SERIAL_CTL, 8'h00);
    settle();
    cmp_val(sel_pullup_out, 8'hff);
    cmp_val(exp_pullup_out, 8'(~de));
    cmp_val({low_addr_pullup_out, high_addr_pullup_out}, {8'(~dl), 1'b1});
    cmp_val({serial_pin_oe_out, serial_pin_out}, 4'hd);
    // expanded mode with boot strap set
    do_reset(1'b1, 1'b1);
    rd(IDX_SERIAL_CTL, 8'h40);
    rd(IDX_CONFIG, 8'h02);
    rd(IDX_EXP_DIR, RST_DIR);
    settle();
    cmp_val(low_addr_pin_oe_out, 8'hff);
    cmp_val(low_addr_pin_out, low_addr_bus_in);
    cmp_val({exp_pin_oe_out[7], exp_pin_out[7]}, {1'b1, rw_strobe_in});
    cmp_val(sel_pin_oe_out, 8'hf0);
    cmp_val(serial_rx_out, serial_pin_in);
    wr(IDX_LOW_DATA, 8'h5a);
    cmp_val(resp, RESP_DECERR);
    rd(IDX_LOW_DATA, 8'h00, RESP_DECERR);
    chip_select_enable_in <= 4'h6;
    wr(IDX_PULLUP, 8'h0f);
    wr(IDX_CONFIG, 8'h03);
    settle();
    cmp_val(sel_pin_oe_out, 8'he0);
    cmp_val(sel_pin_out[6:5], chip_select_in[2:1]);
    cmp_val({low_addr_pullup_out, high_addr_pullup_out}, 9'h0);
    cmp_val({sel_pullup_out, exp_pullup_out}, 16'h1f7f);
    wr(IDX_SEL_DIR, 8'h0f);
    wr(IDX_SEL_DATA, v);
    chip_select_enable_in <= 4'h0;
    settle();
    cmp_val(sel_pin_oe_out, 8'h8f);
    cmp_val(sel_pin_out[3:0], v[3:0]);
    rd(IDX_SEL_DIR, 8'h0f);
    complete_run();
  end
endmodule // tb_top
